// ==== rtl/tsr_pkg.sv ====
package tsr_pkg;
	// Register indices on the plain register port
	localparam logic [1:0]  SOFT_TRAP_ADDR   = 2'h0;
	localparam logic [1:0]  HARD_TRAP_ADDR   = 2'h1;
	localparam int          REG_W            = 16;
	// Field positions
	localparam int          MEM_ADDR_ERR_BIT = 8;
	localparam int          LOOP_OVF_BIT     = 4;
	localparam int          AUX_LOCK_BIT     = 0;
	localparam int          SW_HARD_BIT      = 0;
	localparam int          SOFT_FLAGS       = 3;
	// Reset value of every flag
	localparam logic        FLAG_RESET       = 1'b0;
	localparam logic [15:0] ZERO_WORD        = 16'h0000;
	// Unimplemented positions, which always read zero
	localparam logic [15:0] SOFT_RSVD_MASK   = 16'hfeee;
	localparam logic [15:0] HARD_RSVD_MASK   = 16'hfffe;
endpackage

// ==== rtl/tsr_flag.sv ====
`timescale 1ns/10ps
// One sticky trap flag: an event sets it, a software write loads it
module tsr_flag (
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Set and software access
	input  wire logic set_ev,
	input  wire logic wr_en,
	input  wire logic wr_bit,
	// State
	output logic      flag_q
);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_q <= tsr_pkg::FLAG_RESET; // [RQ6]
		end else if (set_ev) begin
			// Set wins over a clearing write in the same cycle
			flag_q <= 1'b1; // [RQ7]
		end else if (wr_en) begin
			flag_q <= wr_bit; // [RQ6] [RQ7]
		end
	end

	flag_hold_a: assert property (@(posedge clk) // [RQ7]
		disable iff (!arst_n)
		$past(flag_q) && !$past(wr_en) |-> flag_q)
		else $error("flag dropped without a write");
	flag_set_a: assert property (@(posedge clk) // [RQ7]
		disable iff (!arst_n)
		set_ev |=> flag_q)
		else $error("flag not set by event");
endmodule

// ==== rtl/tsr_top.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// RQ1 - Address error event sets soft bit 8
// RQ2 - Loop stack overflow sets soft bit 4
// RQ3 - Aux lock loss sets soft bit 0
// RQ4 - Software hard trap sets hard bit 0
// RQ5 - Unimplemented bits always read zero
// RQ6 - Flags writable, readable, zero after reset
// RQ7 - Flags stay set until software clears
module tsr_top (
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        ARST_N,
	// Trap events, one-cycle pulses
	input  wire logic        MEM_ADDR_ERR_EV,
	input  wire logic        LOOP_OVF_EV,
	input  wire logic        AUX_LOCK_LOSS_EV,
	input  wire logic        SW_HARD_TRAP_EV,
	// Register port
	input  wire logic [1:0]  REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [15:0] REG_RDATA,
	// Flag levels
	output logic             MEMORY_ADDRESS_ERROR_FLAG,
	output logic             LOOP_STACK_OVERFLOW_FLAG,
	output logic             AUX_MULTIPLIER_LOCK_LOSS_FLAG,
	output logic             SOFTWARE_HARD_TRAP_FLAG
);
	logic [2:0]  soft_ev;
	logic [2:0]  soft_bit;
	logic [2:0]  soft_q;
	logic        hard_q;
	logic        wr_soft;
	logic        wr_hard;
	logic [15:0] rd_d;
	logic [15:0] soft_word;
	logic [15:0] hard_word;

	assign wr_soft = REG_WR && (REG_ADDR == tsr_pkg::SOFT_TRAP_ADDR);
	assign wr_hard = REG_WR && (REG_ADDR == tsr_pkg::HARD_TRAP_ADDR);
	assign soft_ev = {MEM_ADDR_ERR_EV, LOOP_OVF_EV, AUX_LOCK_LOSS_EV};
	assign soft_bit = {REG_WDATA[tsr_pkg::MEM_ADDR_ERR_BIT],
		REG_WDATA[tsr_pkg::LOOP_OVF_BIT],
		REG_WDATA[tsr_pkg::AUX_LOCK_BIT]};

	// One cell per soft trap; index 0 is lock loss, 2 is address error
	genvar g;
	generate
		for (g = 0; g < tsr_pkg::SOFT_FLAGS; g++) begin : g_soft
			tsr_flag u_flag (
				.clk    (CORE_CLK),
				.arst_n (ARST_N),
				.set_ev (soft_ev[g]), // [RQ1] [RQ2] [RQ3]
				.wr_en  (wr_soft),
				.wr_bit (soft_bit[g]),
				.flag_q (soft_q[g])
			);
		end
	endgenerate

	tsr_flag u_hard (
		.clk    (CORE_CLK),
		.arst_n (ARST_N),
		.set_ev (SW_HARD_TRAP_EV), // [RQ4]
		.wr_en  (wr_hard),
		.wr_bit (REG_WDATA[tsr_pkg::SW_HARD_BIT]),
		.flag_q (hard_q)
	);

	assign AUX_MULTIPLIER_LOCK_LOSS_FLAG = soft_q[0];
	assign LOOP_STACK_OVERFLOW_FLAG      = soft_q[1];
	assign MEMORY_ADDRESS_ERROR_FLAG     = soft_q[2];
	assign SOFTWARE_HARD_TRAP_FLAG       = hard_q;

	// Only implemented positions are placed; all others stay zero
	always_comb begin
		soft_word = tsr_pkg::ZERO_WORD; // [RQ5]
		soft_word[tsr_pkg::MEM_ADDR_ERR_BIT] = soft_q[2];
		soft_word[tsr_pkg::LOOP_OVF_BIT]     = soft_q[1];
		soft_word[tsr_pkg::AUX_LOCK_BIT]     = soft_q[0];
		hard_word = tsr_pkg::ZERO_WORD; // [RQ5]
		hard_word[tsr_pkg::SW_HARD_BIT] = hard_q;
	end

	// Read word shows the flags before this cycle's events and writes
	always_comb begin
		if (!REG_RD) begin
			rd_d = tsr_pkg::ZERO_WORD;
		end else if (REG_ADDR == tsr_pkg::SOFT_TRAP_ADDR) begin
			rd_d = soft_word; // [RQ6]
		end else if (REG_ADDR == tsr_pkg::HARD_TRAP_ADDR) begin
			rd_d = hard_word; // [RQ6]
		end else begin
			// Unmapped addresses read zero
			rd_d = tsr_pkg::ZERO_WORD;
		end
	end

	// Answer stands one cycle after the strobe; idle cycles give zero
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			REG_RDATA <= tsr_pkg::ZERO_WORD;
		end else begin
			REG_RDATA <= rd_d;
		end
	end

	// Events: each flag is high on the edge after its event
	mem_err_set_a: assert property (@(posedge CORE_CLK) // [RQ1]
		disable iff (!ARST_N)
		MEM_ADDR_ERR_EV |=> MEMORY_ADDRESS_ERROR_FLAG)
		else $error("address error flag not set");
	loop_ovf_set_a: assert property (@(posedge CORE_CLK) // [RQ2]
		disable iff (!ARST_N)
		LOOP_OVF_EV |=> LOOP_STACK_OVERFLOW_FLAG)
		else $error("loop overflow flag not set");
	aux_lock_set_a: assert property (@(posedge CORE_CLK) // [RQ3]
		disable iff (!ARST_N)
		AUX_LOCK_LOSS_EV |=> AUX_MULTIPLIER_LOCK_LOSS_FLAG)
		else $error("lock loss flag not set");
	hard_trap_set_a: assert property (@(posedge CORE_CLK) // [RQ4]
		disable iff (!ARST_N)
		SW_HARD_TRAP_EV |=> SOFTWARE_HARD_TRAP_FLAG)
		else $error("hard trap flag not set");

	// Flags move only on an event or a write to their register
	soft_stable_a: assert property (@(posedge CORE_CLK) // [RQ7]
		disable iff (!ARST_N)
		!wr_soft && !(|soft_ev) |=> $stable(soft_q))
		else $error("soft flag changed without cause");
	hard_stable_a: assert property (@(posedge CORE_CLK) // [RQ7]
		disable iff (!ARST_N)
		!wr_hard && !SW_HARD_TRAP_EV |=> $stable(hard_q))
		else $error("hard flag changed without cause");

	// Writes land on the next edge; an event in that cycle still wins
	soft_write_a: assert property (@(posedge CORE_CLK) // [RQ6]
		disable iff (!ARST_N)
		wr_soft |=> soft_q == ($past(soft_bit) | $past(soft_ev)))
		else $error("soft register write not applied");
	hard_write_a: assert property (@(posedge CORE_CLK) // [RQ6]
		disable iff (!ARST_N)
		wr_hard |=> hard_q == ($past(REG_WDATA[tsr_pkg::SW_HARD_BIT])
		|| $past(SW_HARD_TRAP_EV)))
		else $error("hard register write not applied");
	hard_wset_a: assert property (@(posedge CORE_CLK) // [RQ7]
		disable iff (!ARST_N)
		wr_hard && REG_WDATA[tsr_pkg::SW_HARD_BIT]
		|=> SOFTWARE_HARD_TRAP_FLAG)
		else $error("hard trap flag not set by write");
	clear_write_a: assert property (@(posedge CORE_CLK) // [RQ7]
		disable iff (!ARST_N)
		REG_WR && REG_ADDR == tsr_pkg::HARD_TRAP_ADDR
		&& !REG_WDATA[tsr_pkg::SW_HARD_BIT]
		&& !SW_HARD_TRAP_EV |=> !SOFTWARE_HARD_TRAP_FLAG)
		else $error("hard trap flag not cleared");

	// Per soft flag: a written one sets it, a written zero clears it
	for (genvar k = 0; k < tsr_pkg::SOFT_FLAGS; k++) begin : g_soft_chk
		soft_wset_a: assert property (@(posedge CORE_CLK) // [RQ7]
			disable iff (!ARST_N)
			wr_soft && soft_bit[k] |=> soft_q[k])
			else $error("soft flag not set by write");
		soft_clear_a: assert property (@(posedge CORE_CLK) // [RQ7]
			disable iff (!ARST_N)
			wr_soft && !soft_bit[k] && !soft_ev[k] |=> !soft_q[k])
			else $error("soft flag not cleared by write");
	end

	// Read word follows the strobe by one cycle, then returns to zero
	soft_zero_a: assert property (@(posedge CORE_CLK) // [RQ5]
		disable iff (!ARST_N)
		$past(REG_RD) && $past(REG_ADDR) == tsr_pkg::SOFT_TRAP_ADDR
		|-> (REG_RDATA & tsr_pkg::SOFT_RSVD_MASK)
		== tsr_pkg::ZERO_WORD)
		else $error("soft register reserved bits nonzero");
	hard_zero_a: assert property (@(posedge CORE_CLK) // [RQ5]
		disable iff (!ARST_N)
		$past(REG_ADDR) == tsr_pkg::HARD_TRAP_ADDR
		|-> (REG_RDATA & tsr_pkg::HARD_RSVD_MASK)
		== tsr_pkg::ZERO_WORD)
		else $error("hard register reserved bits nonzero");
	soft_read_a: assert property (@(posedge CORE_CLK) // [RQ6]
		disable iff (!ARST_N)
		REG_RD && REG_ADDR == tsr_pkg::SOFT_TRAP_ADDR && !REG_WR
		|=> REG_RDATA[tsr_pkg::MEM_ADDR_ERR_BIT]
		== $past(MEMORY_ADDRESS_ERROR_FLAG)
		&& REG_RDATA[tsr_pkg::LOOP_OVF_BIT]
		== $past(LOOP_STACK_OVERFLOW_FLAG)
		&& REG_RDATA[tsr_pkg::AUX_LOCK_BIT]
		== $past(AUX_MULTIPLIER_LOCK_LOSS_FLAG))
		else $error("soft register read mismatch");
	hard_read_a: assert property (@(posedge CORE_CLK) // [RQ6]
		disable iff (!ARST_N)
		REG_RD && REG_ADDR == tsr_pkg::HARD_TRAP_ADDR && !REG_WR
		|=> REG_RDATA[tsr_pkg::SW_HARD_BIT]
		== $past(SOFTWARE_HARD_TRAP_FLAG))
		else $error("hard register read mismatch");
	unmapped_zero_a: assert property (@(posedge CORE_CLK) // [RQ5]
		disable iff (!ARST_N)
		REG_RD && REG_ADDR != tsr_pkg::SOFT_TRAP_ADDR
		&& REG_ADDR != tsr_pkg::HARD_TRAP_ADDR
		|=> REG_RDATA == tsr_pkg::ZERO_WORD)
		else $error("unmapped address read nonzero");
	rdata_idle_a: assert property (@(posedge CORE_CLK) // [RQ6]
		disable iff (!ARST_N)
		!REG_RD |=> REG_RDATA == tsr_pkg::ZERO_WORD)
		else $error("read data held past its cycle");

	// Main scenarios
	soft_set_c: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
		MEM_ADDR_ERR_EV ##1 REG_RD);
	clear_c: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
		SOFTWARE_HARD_TRAP_FLAG ##1 !SOFTWARE_HARD_TRAP_FLAG);
	race_c: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
		LOOP_OVF_EV && wr_soft && !REG_WDATA[tsr_pkg::LOOP_OVF_BIT]);
	unmapped_c: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
		REG_RD && REG_ADDR != tsr_pkg::SOFT_TRAP_ADDR
		&& REG_ADDR != tsr_pkg::HARD_TRAP_ADDR);
	hard_race_c: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
		SW_HARD_TRAP_EV && wr_hard
		&& !REG_WDATA[tsr_pkg::SW_HARD_BIT]);
endmodule

// ==== tb/test_trap_status_registers.sv ====
`timescale 1ns/10ps
module test_trap_status_registers;
	logic        CORE_CLK = 1'b0;
	logic        ARST_N = 1'b0;
	logic [3:0]  ev = 4'h0;
	logic [1:0]  addr = 2'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] rdata;
	logic [3:0]  flags;
	logic [3:0]  exp_f = 4'h0;
	logic [15:0] exp_rd = 16'h0000;
	logic [31:0] r;
	int          num_errors = 0;
	int          compares = 0;
	int          seed = 32'hdb29;

	always #5 CORE_CLK = ~CORE_CLK;

	tsr_top dut (
		.CORE_CLK                      (CORE_CLK),
		.ARST_N                        (ARST_N),
		.MEM_ADDR_ERR_EV               (ev[0]),
		.LOOP_OVF_EV                   (ev[1]),
		.AUX_LOCK_LOSS_EV              (ev[2]),
		.SW_HARD_TRAP_EV               (ev[3]),
		.REG_ADDR                      (addr),
		.REG_WDATA                     (wdata),
		.REG_WR                        (wr),
		.REG_RD                        (rd),
		.REG_RDATA                     (rdata),
		.MEMORY_ADDRESS_ERROR_FLAG     (flags[0]),
		.LOOP_STACK_OVERFLOW_FLAG      (flags[1]),
		.AUX_MULTIPLIER_LOCK_LOSS_FLAG (flags[2]),
		.SOFTWARE_HARD_TRAP_FLAG       (flags[3])
	);

	function automatic logic [15:0] exp_word(logic [1:0] a, logic [3:0] f);
		if (a == 2'h0) return {7'h00, f[0], 3'h0, f[1], 3'h0, f[2]};
		if (a == 2'h1) return {15'h0000, f[3]};
		return 16'h0000;
	endfunction

	// Event is OR-ed last so it wins over a clearing write
	function automatic logic [3:0] next_f(logic [3:0] f, logic [3:0] e,
			logic w, logic [1:0] a, logic [15:0] d);
		logic [3:0] n;
		n = f;
		if (w && a == 2'h0) n[2:0] = {d[0], d[4], d[8]};
		if (w && a == 2'h1) n[3] = d[0];
		return n | e;
	endfunction

	task summarize;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task chk_flags(input logic [3:0] got);
		compares++;
		if (got !== exp_f) begin
			num_errors++;
			$display("[FAIL] %0t flags %h exp %h", $time, got, exp_f);
		end
	endtask

	task chk_rdata(input logic [15:0] got);
		compares++;
		if (got !== exp_rd) begin
			num_errors++;
			$display("[FAIL] %0t rdata %h exp %h", $time, got, exp_rd);
		end
	endtask

	// Outputs at the falling edge reflect the op taken one edge earlier
	task step(input logic [3:0] e, input logic w, input logic rq,
			input logic [1:0] a, input logic [15:0] d);
		@(posedge CORE_CLK);
		ev <= e;
		wr <= w;
		rd <= rq;
		addr <= a;
		wdata <= d;
		@(negedge CORE_CLK);
		chk_flags(flags);
		chk_rdata(rdata);
		exp_rd = rq ? exp_word(a, exp_f) : 16'h0000;
		exp_f = next_f(exp_f, e, w, a, d);
	endtask

	initial begin
		repeat (16) @(posedge CORE_CLK);
		ARST_N <= 1'b1;
		step(4'h0, 1'b0, 1'b1, 2'h0, 16'h0000);
		step(4'h0, 1'b1, 1'b0, 2'h0, 16'hffff);
		step(4'h0, 1'b1, 1'b0, 2'h1, 16'hffff);
		step(4'h0, 1'b0, 1'b1, 2'h0, 16'h0000);
		step(4'h0, 1'b0, 1'b1, 2'h1, 16'h0000);
		step(4'h2, 1'b1, 1'b0, 2'h0, 16'h0000);
		step(4'h0, 1'b0, 1'b1, 2'h2, 16'h0000);
		step(4'h8, 1'b1, 1'b0, 2'h1, 16'h0000);
		step(4'h0, 1'b0, 1'b1, 2'h3, 16'h0000);
		for (int i = 0; i < 3000; i++) begin
			r = $random(seed);
			step({&r[15:13], &r[12:10], &r[9:7], &r[6:4]}, r[1:0] == 2'h1,
				r[1:0] == 2'h2, r[3:2], 16'($random(seed)));
		end
		step(4'h0, 1'b0, 1'b0, 2'h0, 16'h0000);
		summarize();
	end
endmodule
